// >>> pcm_ctl_props.sv
// Port assertions for the clock and power mode block
module pcm_ctl_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Bus answer
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // Mode pins
  input wire logic IDLE,
  input wire logic MC_TICK,
  input wire logic PERIPH_TICK,
  input wire logic CLK_RUN,
  input wire logic CORE_RESET,
  input wire logic ALE_FORCE_LOW,
  input wire logic PROGRAM_STORE_STROBE_FORCE_LOW,
  input wire logic PORT0_FLOAT
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  sequence s_gap;
    !MC_TICK [*3];
  endsequence
  sequence s_hold;
    CORE_RESET [*8];
  endsequence
  chk_tick_gap: assert property (MC_TICK |=> s_gap) else $error("short cycle");
  chk_rst_len: assert property ($rose(CORE_RESET) |-> s_hold) else $error("short reset");
  chk_rst_rate: assert property (CORE_RESET && MC_TICK |-> ##4 MC_TICK) else $error("slow rate");
  chk_pd_strobe: assert property (!CLK_RUN |-> ALE_FORCE_LOW && PROGRAM_STORE_STROBE_FORCE_LOW) else $error("strobe");
  chk_pd_float: assert property (PORT0_FLOAT |-> !CLK_RUN) else $error("float while running");
  chk_pd_halt: assert property (!CLK_RUN |-> !MC_TICK) else $error("tick while halted");
  chk_periph_rate: assert property (MC_TICK && !IDLE |=> PERIPH_TICK) else $error("lost strobe");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("answer dropped");
endmodule
bind pcm_power_clock_mode_control pcm_ctl_props u_props (.MCLK, .RST, .S_AXI_BVALID, .S_AXI_BREADY, .IDLE,
  .MC_TICK, .PERIPH_TICK, .CLK_RUN, .CORE_RESET, .ALE_FORCE_LOW, .PROGRAM_STORE_STROBE_FORCE_LOW, .PORT0_FLOAT);

// >>> pcm_cycle_gen.sv
// Machine-cycle strobe generator with boundary-aligned rate changes
module pcm_cycle_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Rate request in, machine-cycle strobe out
  pcm_tick_if.gen tif
);
  typedef struct packed {
    logic [9:0] cnt;
    pcm_pkg::pcm_div_t cur;
    logic tick;
  } pcm_gen_t;

  pcm_gen_t s_q;
  pcm_gen_t s_d;
  logic [9:0] last;

  always_comb begin
    unique case (s_q.cur)
      pcm_pkg::DIV_64: last = pcm_pkg::LAST_64;
      pcm_pkg::DIV_1024: last = pcm_pkg::LAST_1024;
      default: last = pcm_pkg::LAST_4;
    endcase
    s_d = s_q;
    s_d.tick = 1'b0;
    // Stopped clock freezes the count where it stands
    if (tif.run) begin
      if (s_q.cnt == last) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
        // New rate only at a wrap, so no short machine cycle appears
        s_d.cur = tif.div_req;
      end else begin
        s_d.cnt = s_q.cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.cnt <= '0;
      s_q.cur <= pcm_pkg::DIV_4;
      s_q.tick <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tif.tick = s_q.tick;
endmodule

// >>> pcm_pkg.sv
// Shared constants and types for the power and clock mode control block
package pcm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_PMODE = 8'h00;
  localparam logic [7:0] OFF_EXT = 8'h04;
  localparam logic [7:0] OFF_PCTL = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ = 8'h10;
  localparam logic [7:0] OFF_WDG = 8'h14;
  // power_mode_reg fields
  localparam int PM_DIV_HI = 7;
  localparam int PM_DIV_LO = 6;
  localparam int PM_SWB = 5;
  // extended_irq_flag_reg fields
  localparam int EX_SRC_SEL = 3;
  localparam int EX_SRC_IND = 2;
  localparam int EX_WAKE_RC = 1;
  localparam int EX_AMP_OFF = 0;
  // power_control_reg, status, interrupt and watchdog fields
  localparam int PC_PD = 1;
  localparam int ST_POR = 0;
  localparam int ST_WDIF = 1;
  localparam int ST_WDRF = 2;
  localparam int ST_CRYSTAL_READY_FLAG = 4;
  localparam int IR_EN = 1;
  localparam int IR_LVL = 3;
  localparam int IR_GE = 7;
  localparam int WD_REN = 0;
  localparam int WD_CLR = 1;
  // Reset values
  localparam logic [7:0] PM_RST = 8'h40;
  localparam logic EX_SRC_RST = 1'b1;
  // Machine-cycle divide codes and last clock index of a machine cycle
  typedef enum logic [1:0] {
    DIV_RSV = 2'h0, DIV_4 = 2'h1, DIV_64 = 2'h2, DIV_1024 = 2'h3
  } pcm_div_t;
  localparam logic [9:0] LAST_4 = 10'h003;
  localparam logic [9:0] LAST_64 = 10'h03f;
  localparam logic [9:0] LAST_1024 = 10'h3ff;
  // Watchdog reset delay in oscillator clocks, reset stretch in machine cycles
  localparam int unsigned WDT_RST_CLKS = 512;
  localparam logic [9:0] WDT_LAST = 10'(WDT_RST_CLKS - 1);
  localparam int unsigned RST_STRETCH_MC = 2;
  localparam logic [9:0] RST_STRETCH_LAST = 10'(RST_STRETCH_MC - 1);
  // Idle peripheral rate is clock/4
  localparam logic [1:0] IDLE_LAST = 2'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchronised pin slots
  localparam int NSYNC = 5;
  localparam int SY_RST = 0;
  localparam int SY_RXD = 1;
  localparam int SY_INT = 3;
  localparam int SY_XTAL = 4;
  localparam logic [4:0] SYNC_RST = 5'h0e;
  // States
  typedef enum logic [1:0] {PWR_RUN = 2'b01, PWR_DOWN = 2'b10} pcm_pwr_t;
  typedef enum logic [3:0] {
    RS_IDLE = 4'b0001, RS_WDWAIT = 4'b0010, RS_HOLD = 4'b0100, RS_STRETCH = 4'b1000
  } pcm_rst_st_t;
endpackage

// >>> pcm_power_clock_mode_control.sv
// Clock rate, clock source and power state control with an AXI4-Lite slave
//
// Contract
// - Divide field codes 01, 10, 11 give 4, 64, 1024 clocks; 00 reserved.
// - Reset and default rate is four clocks per machine cycle.
// - Economy: peripherals follow core rate; idle: peripherals run at clock/4.
// - A new rate takes effect one instruction cycle after its write.
// - Source select picks crystal or RC; indicator shows it; one-instruction delay.
// - Crystal-ready flag set after warm-up; crystal select ignored while it is 0.
// - Enabled switchback returns to /4 on serial activity or acknowledged interrupt.
// - Receive start-bit falling edge or transmit buffer write triggers switchback.
// - Switchback ignores serial flags; software may slow down again later.
// - Divide writes ignored during serial transfer while switchback enabled.
// - Watchdog, power-on or external reset forces the /4 rate.
// - Writing power-down stops clocks once the writing instruction completes.
// - In power-down both strobes low; port 0 floats with external program.
// - Reset pin high ends power-down and restarts at 0000h; watchdog cannot.
// - Enabled low-level external interrupt wakes from power-down and resumes.
// - Wake-source bit set: wake on RC, move to crystal once stable.
// - Reset pin sampled each machine cycle; hold it high two cycles.
// - Reset lasts while pin high plus two machine cycles, then 0000h.
// - Power-on reset sets power-on flag; software clears it after reading.
// - Watchdog timeout sets flag; uncleared for 512 clocks resets two cycles.
module pcm_power_clock_mode_control (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AXI4-Lite write address and data
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Pins from outside this clock domain
  input wire logic RST_PIN,
  input wire logic RXD,
  input wire logic [1:0] INT_N,
  input wire logic XTAL_STABLE,
  // Core and peripheral events on this clock
  input wire logic INSTR_END,
  input wire logic IDLE,
  input wire logic REN,
  input wire logic TX_BUF_WR,
  input wire logic SER_BUSY,
  input wire logic [1:0] IRQ_ACK,
  input wire logic WDT_TIMEOUT,
  input wire logic EXT_PROG,
  // Clock, source and power outputs
  output logic MC_TICK,
  output logic PERIPH_TICK,
  output logic CLK_RUN,
  output logic OSC_USE_CRYSTAL,
  output logic XTAL_AMP_EN,
  output logic CORE_RESET,
  output logic ALE_FORCE_LOW,
  output logic PROGRAM_STORE_STROBE_FORCE_LOW,
  output logic PORT0_FLOAT
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [pcm_pkg::NSYNC-1:0] sy1;
    logic [pcm_pkg::NSYNC-1:0] sy2;
    logic rx_prev;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [7:0] w_data;
    logic w_be;
    logic awr;
    logic wr;
    logic arr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    pcm_pkg::pcm_div_t div_reg;
    pcm_pkg::pcm_div_t div_req;
    logic div_pend;
    logic swb_en;
    logic osc_sel;
    logic osc_cur;
    logic src_pend;
    logic src_arm;
    logic amp_off;
    logic wake_rc;
    logic auto_xt;
    logic xt_rdy;
    logic ge;
    logic [1:0] ie;
    logic [1:0] lvl;
    logic wdt_ren;
    logic wdt_clr;
    pcm_pkg::pcm_pwr_t pwr;
    logic pd_pend;
    logic por_f;
    logic wdif;
    logic wdrf;
    logic [1:0] p4;
    logic ptick;
    logic core_rst;
    logic xamp;
    logic strb_low;
    logic p0f;
  } pcm_main_t;

  pcm_main_t s_q;
  pcm_main_t s_d;

  pcm_tick_if tif ();

  logic core_rst;
  logic wd_fire;
  logic pin_hi;
  logic rx_fall;
  logic [1:0] int_low;
  logic wr_go;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [7:0] rd;
  logic rd_hit;
  logic wr_hit;
  logic swb_evt;
  logic wake_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Machine-cycle timing and reset handling

  assign tif.run = (s_d.pwr == pcm_pkg::PWR_RUN);
  assign tif.div_req = s_q.div_req;

  pcm_cycle_gen u_gen (
    .clk (MCLK),
    .rst (RST),
    .tif (tif)
  );

  pcm_reset_ctl u_rst (
    .clk (MCLK),
    .rst (RST),
    .tif (tif),
    .pin_hi (pin_hi),
    .wdt_to (WDT_TIMEOUT),
    .wdt_clr (s_q.wdt_clr),
    .wdt_ren (s_q.wdt_ren),
    .core_rst (core_rst),
    .wd_fire (wd_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    pin_hi = s_q.sy2[pcm_pkg::SY_RST];
    int_low = ~s_q.sy2[pcm_pkg::SY_INT -: 2];
    rx_fall = s_q.rx_prev && !s_q.sy2[pcm_pkg::SY_RXD];
    wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    wr_off = {s_q.aw_addr[7:2], 2'b00};
    rd_off = {S_AXI_ARADDR[7:2], 2'b00};
    rd = '0;
    rd_hit = 1'b1;
    wr_hit = 1'b1;
    swb_evt = 1'b0;
    wake_irq = 1'b0;

    // Two-stage pin synchroniser
    s_d.sy1 = {XTAL_STABLE, INT_N, RXD, RST_PIN};
    s_d.sy2 = s_q.sy1;
    s_d.rx_prev = s_q.sy2[pcm_pkg::SY_RXD];
    s_d.wdt_clr = 1'b0;

    // Bus channel acceptance
    if (S_AXI_AWVALID && s_q.awr) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_q.wr) begin
      s_d.w_have = 1'b1;
      s_d.w_data = S_AXI_WDATA[7:0];
      s_d.w_be = S_AXI_WSTRB[0];
    end
    if (s_q.bvalid && S_AXI_BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && S_AXI_RREADY) begin
      s_d.rvalid = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes; all fields sit in byte lane 0
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      unique case (wr_off)
        pcm_pkg::OFF_PMODE: begin
          if (s_q.w_be) begin
            s_d.swb_en = s_q.w_data[pcm_pkg::PM_SWB];
            // Reserved code and writes during a serial transfer with switchback enabled leave the rate alone
            if (s_q.w_data[pcm_pkg::PM_DIV_HI -: 2] != pcm_pkg::DIV_RSV
                && !(s_q.swb_en && SER_BUSY)) begin
              s_d.div_reg = pcm_pkg::pcm_div_t'(s_q.w_data[pcm_pkg::PM_DIV_HI -: 2]);
              s_d.div_pend = 1'b1;
            end
          end
        end
        pcm_pkg::OFF_EXT: begin
          if (s_q.w_be) begin
            s_d.amp_off = s_q.w_data[pcm_pkg::EX_AMP_OFF];
            s_d.wake_rc = s_q.w_data[pcm_pkg::EX_WAKE_RC];
            // Crystal cannot be chosen before it is warm
            if (!s_q.w_data[pcm_pkg::EX_SRC_SEL] || s_q.xt_rdy) begin
              s_d.osc_sel = s_q.w_data[pcm_pkg::EX_SRC_SEL];
              s_d.src_pend = 1'b1;
            end
          end
        end
        pcm_pkg::OFF_PCTL: begin
          if (s_q.w_be && s_q.w_data[pcm_pkg::PC_PD]) begin
            s_d.pd_pend = 1'b1;
          end
        end
        pcm_pkg::OFF_STAT: begin
          if (s_q.w_be) begin
            if (s_q.w_data[pcm_pkg::ST_POR]) begin
              s_d.por_f = 1'b0;
            end
            if (s_q.w_data[pcm_pkg::ST_WDIF]) begin
              s_d.wdif = 1'b0;
            end
            if (s_q.w_data[pcm_pkg::ST_WDRF]) begin
              s_d.wdrf = 1'b0;
            end
          end
        end
        pcm_pkg::OFF_IRQ: begin
          if (s_q.w_be) begin
            s_d.ie = s_q.w_data[pcm_pkg::IR_EN -: 2];
            s_d.lvl = s_q.w_data[pcm_pkg::IR_LVL -: 2];
            s_d.ge = s_q.w_data[pcm_pkg::IR_GE];
          end
        end
        pcm_pkg::OFF_WDG: begin
          if (s_q.w_be) begin
            s_d.wdt_ren = s_q.w_data[pcm_pkg::WD_REN];
            s_d.wdt_clr = s_q.w_data[pcm_pkg::WD_CLR];
          end
        end
        default: wr_hit = 1'b0;
      endcase
      s_d.bresp = wr_hit ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    if (S_AXI_ARVALID && s_q.arr) begin
      unique case (rd_off)
        pcm_pkg::OFF_PMODE: begin
          rd[pcm_pkg::PM_DIV_HI -: 2] = s_q.div_reg;
          rd[pcm_pkg::PM_SWB] = s_q.swb_en;
        end
        pcm_pkg::OFF_EXT: begin
          rd[pcm_pkg::EX_SRC_SEL] = s_q.osc_sel;
          rd[pcm_pkg::EX_SRC_IND] = !s_q.osc_cur;
          rd[pcm_pkg::EX_WAKE_RC] = s_q.wake_rc;
          rd[pcm_pkg::EX_AMP_OFF] = s_q.amp_off;
        end
        pcm_pkg::OFF_PCTL: rd[pcm_pkg::PC_PD] = s_q.pd_pend;
        pcm_pkg::OFF_STAT: begin
          rd[pcm_pkg::ST_POR] = s_q.por_f;
          rd[pcm_pkg::ST_WDIF] = s_q.wdif;
          rd[pcm_pkg::ST_WDRF] = s_q.wdrf;
          rd[pcm_pkg::ST_CRYSTAL_READY_FLAG] = s_q.xt_rdy;
        end
        pcm_pkg::OFF_IRQ: begin
          rd[pcm_pkg::IR_EN -: 2] = s_q.ie;
          rd[pcm_pkg::IR_LVL -: 2] = s_q.lvl;
          rd[pcm_pkg::IR_GE] = s_q.ge;
        end
        pcm_pkg::OFF_WDG: rd[pcm_pkg::WD_REN] = s_q.wdt_ren;
        default: rd_hit = 1'b0;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rd_hit ? pcm_pkg::RESP_OKAY : pcm_pkg::RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // Delayed rate and source hand-over
    // The generator loads div_req only at a wrap, so the rate moves
    // at the first boundary after the writing instruction has ended.
    if (INSTR_END && s_q.div_pend) begin
      s_d.div_req = s_q.div_reg;
      s_d.div_pend = 1'b0;
    end
    if (INSTR_END && s_q.src_pend) begin
      s_d.src_arm = 1'b1;
      s_d.src_pend = 1'b0;
    end
    if (tif.tick && s_q.src_arm) begin
      s_d.osc_cur = s_q.osc_sel;
      s_d.src_arm = 1'b0;
    end
    // After an RC wake-up, return to the crystal once it is warm
    if (tif.tick && s_q.auto_xt && s_q.xt_rdy) begin
      s_d.osc_cur = s_q.osc_sel;
      s_d.auto_xt = 1'b0;
    end
    s_d.xt_rdy = s_q.sy2[pcm_pkg::SY_XTAL] && !s_q.amp_off && !s_q.strb_low;

    ////////////////////////////////////////////////////////////////////////
    // Switchback; serial interrupt flags play no part in it
    swb_evt = s_q.swb_en && ((rx_fall && REN) || TX_BUF_WR
              || (s_q.ge && |(IRQ_ACK & s_q.ie)));
    if (swb_evt) begin
      s_d.div_reg = pcm_pkg::DIV_4;
      s_d.div_req = pcm_pkg::DIV_4;
      s_d.div_pend = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state
    wake_irq = s_q.ge && |(int_low & s_q.ie & s_q.lvl);
    unique case (s_q.pwr)
      pcm_pkg::PWR_RUN: begin
        if (s_q.pd_pend && INSTR_END) begin
          s_d.pwr = pcm_pkg::PWR_DOWN;
          s_d.pd_pend = 1'b0;
        end
      end
      pcm_pkg::PWR_DOWN: begin
        // Watchdog events cannot reach here: its counter needs the clock
        if (pin_hi) begin
          s_d.pwr = pcm_pkg::PWR_RUN;
        end else if (wake_irq) begin
          s_d.pwr = pcm_pkg::PWR_RUN;
          if (s_q.wake_rc) begin
            s_d.osc_cur = 1'b0;
            s_d.auto_xt = s_q.osc_sel;
          end
        end
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Flags: a hardware set wins over a software clear
    if (WDT_TIMEOUT) begin
      s_d.wdif = 1'b1;
    end
    if (wd_fire) begin
      s_d.wdrf = 1'b1;
    end

    // Any core reset forces the fast rate and cancels power-down
    if (core_rst) begin
      s_d.div_reg = pcm_pkg::DIV_4;
      s_d.div_req = pcm_pkg::DIV_4;
      s_d.div_pend = 1'b0;
      s_d.pd_pend = 1'b0;
      s_d.pwr = pcm_pkg::PWR_RUN;
    end
    s_d.core_rst = core_rst;

    ////////////////////////////////////////////////////////////////////////
    // Peripheral rate: core rate in economy, clock/4 in idle
    s_d.p4 = s_q.p4 + 2'h1;
    s_d.ptick = IDLE ? (s_d.pwr == pcm_pkg::PWR_RUN && s_q.p4 == pcm_pkg::IDLE_LAST)
                : tif.tick;

    // Pin states in power-down
    s_d.strb_low = (s_d.pwr == pcm_pkg::PWR_DOWN);
    s_d.p0f = s_d.strb_low && EXT_PROG;
    s_d.xamp = !s_d.amp_off && !s_d.strb_low;

    // Channel readies; one write and one read in flight at a time
    s_d.awr = !s_d.aw_have && !s_d.bvalid;
    s_d.wr = !s_d.w_have && !s_d.bvalid;
    s_d.arr = !s_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.sy1 <= pcm_pkg::SYNC_RST;
      s_q.sy2 <= pcm_pkg::SYNC_RST;
      s_q.rx_prev <= 1'b1;
      s_q.div_reg <= pcm_pkg::pcm_div_t'(pcm_pkg::PM_RST[pcm_pkg::PM_DIV_HI -: 2]);
      s_q.div_req <= pcm_pkg::DIV_4;
      s_q.swb_en <= pcm_pkg::PM_RST[pcm_pkg::PM_SWB];
      s_q.osc_sel <= pcm_pkg::EX_SRC_RST;
      s_q.osc_cur <= pcm_pkg::EX_SRC_RST;
      s_q.pwr <= pcm_pkg::PWR_RUN;
      s_q.por_f <= 1'b1;
      s_q.xamp <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign S_AXI_AWREADY = s_q.awr;
  assign S_AXI_WREADY = s_q.wr;
  assign S_AXI_BVALID = s_q.bvalid;
  assign S_AXI_BRESP = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arr;
  assign S_AXI_RVALID = s_q.rvalid;
  assign S_AXI_RDATA = {24'h000000, s_q.rdata};
  assign S_AXI_RRESP = s_q.rresp;
  assign MC_TICK = tif.tick;
  assign PERIPH_TICK = s_q.ptick;
  assign CLK_RUN = !s_q.strb_low;
  assign OSC_USE_CRYSTAL = s_q.osc_cur;
  assign XTAL_AMP_EN = s_q.xamp;
  assign CORE_RESET = s_q.core_rst;
  assign ALE_FORCE_LOW = s_q.strb_low;
  assign PROGRAM_STORE_STROBE_FORCE_LOW = s_q.strb_low;
  assign PORT0_FLOAT = s_q.p0f;
endmodule

// >>> pcm_power_clock_mode_control_bench.sv
// Self-checking bench for the clock and power mode block
module pcm_power_clock_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0, ren = 1'b1;
  logic rpin = 1'b0, rxd = 1'b1, xs = 1'b1, ie = 1'b0, idle = 1'b0, txw = 1'b0, busy = 1'b0, wto = 1'b0, ep = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [1:0] bresp, rresp, rs, int_n = 2'h3, ack = 2'h0;
  logic awr, wrd, bv, arr, rv, tick, ptick, run, xtal, amp, crst, ale, program_store_strobe, p0f;
  logic [1:0] codes [5] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h2};
  int n_mismatch = 0, total_checks = 0, n;
  pcm_power_clock_mode_control uut (.MCLK(mclk), .RST(rst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp),
    .RST_PIN(rpin), .RXD(rxd), .INT_N(int_n), .XTAL_STABLE(xs), .INSTR_END(ie), .IDLE(idle), .REN(ren),
    .TX_BUF_WR(txw), .SER_BUSY(busy), .IRQ_ACK(ack), .WDT_TIMEOUT(wto), .EXT_PROG(ep), .MC_TICK(tick),
    .PERIPH_TICK(ptick), .CLK_RUN(run), .OSC_USE_CRYSTAL(xtal), .XTAL_AMP_EN(amp), .CORE_RESET(crst),
    .ALE_FORCE_LOW(ale), .PROGRAM_STORE_STROBE_FORCE_LOW(program_store_strobe), .PORT0_FLOAT(p0f));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Frequent instruction ends keep pending changes moving
  always @(posedge mclk) begin
    ie <= ($urandom % 4) != 0;
    idle <= ($urandom % 8) == 0;
  end
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task lim(input int k, input int m);
    if (k >= m) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge mclk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'($urandom), d};
    bre <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && k < 100);
    bre <= 1'b0;
    lim(k, 100);
  endtask
  task automatic rreg(input logic [7:0] a);
    int k = 0;
    @(posedge mclk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
      if (arr) arv <= 1'b0;
    end while (!rv && k < 100);
    q = rd;
    rs = rresp;
    rre <= 1'b0;
    lim(k, 100);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rreg(a);
    chk(q, e);
  endtask
  task automatic ticks(input int c);
    int k = 0;
    repeat (c) begin
      do begin
        @(posedge mclk);
        k++;
      end while (!tick && k < 5000);
    end
    lim(k, 5000);
  endtask
  function automatic int clocks(input logic [1:0] c);
    return (c == 2'h2) ? 64 : (c == 2'h3) ? 1024 : 4;
  endfunction
  // Three boundaries first, so a pending rate change has landed
  task automatic per(input int e);
    int k = 0;
    ticks(3);
    do begin
      @(posedge mclk);
      k++;
    end while (!tick && k < 1100);
    chk(k, e);
  endtask
  // Wait until run (w low) or core reset (w high) reaches v
  task automatic wt(input logic w, input logic v);
    int k = 0;
    while ((w ? crst : run) !== v && k < 3000) begin
      @(posedge mclk);
      k++;
    end
    lim(k, 3000);
    n = k;
  endtask
  task pulse_wdt;
    @(posedge mclk);
    wto <= 1'b1;
    @(posedge mclk);
    wto <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(62));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rchk(pcm_pkg::OFF_PMODE, 32'h40);
    per(4);
    rchk(pcm_pkg::OFF_STAT, 32'h11);
    wreg(pcm_pkg::OFF_STAT, 8'h01);
    rchk(pcm_pkg::OFF_STAT, 32'h10);
    wreg(8'h3c, 8'h01);
    chk(bresp, pcm_pkg::RESP_SLVERR);
    rchk(8'h3c, 32'h0);
    chk(rs, pcm_pkg::RESP_SLVERR);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wreg(pcm_pkg::OFF_PMODE, {codes[i], 6'h0});
      per(clocks(codes[i]));
    end
    wreg(pcm_pkg::OFF_PMODE, 8'h00);
    rchk(pcm_pkg::OFF_PMODE, 32'h80);
    wreg(pcm_pkg::OFF_IRQ, 8'h83);
    for (int i = 0; i < 4; i++) begin
      wreg(pcm_pkg::OFF_PMODE, 8'ha0);
      rchk(pcm_pkg::OFF_PMODE, 32'ha0);
      txw <= (i == 0);
      ren <= (i != 3);
      rxd <= (i % 2 == 0);
      ack <= {1'b0, i == 2};
      @(posedge mclk);
      txw <= 1'b0;
      ack <= 2'h0;
      repeat (6) @(posedge mclk);
      rxd <= 1'b1;
      rchk(pcm_pkg::OFF_PMODE, i == 3 ? 32'ha0 : 32'h60);
    end
    busy <= 1'b1;
    wreg(pcm_pkg::OFF_PMODE, 8'h60);
    rchk(pcm_pkg::OFF_PMODE, 32'ha0);
    busy <= 1'b0;
    wreg(pcm_pkg::OFF_PMODE, 8'h40);
    $display("rate test done");
    wreg(pcm_pkg::OFF_EXT, 8'h01);
    ticks(3);
    chk({xtal, amp}, 2'h0);
    rchk(pcm_pkg::OFF_EXT, 32'h05);
    wreg(pcm_pkg::OFF_EXT, 8'h00);
    xs <= 1'b0;
    ticks(2);
    wreg(pcm_pkg::OFF_EXT, 8'h08);
    ticks(3);
    chk(xtal, 1'b0);
    xs <= 1'b1;
    ticks(2);
    wreg(pcm_pkg::OFF_EXT, 8'h0a);
    ticks(3);
    chk(xtal, 1'b1);
    $display("source test done");
    ep <= 1'($urandom);
    wreg(pcm_pkg::OFF_PMODE, 8'h80);
    wreg(pcm_pkg::OFF_IRQ, 8'h85);
    wreg(pcm_pkg::OFF_PCTL, 8'h02);
    wt(1'b0, 1'b0);
    chk({ale, program_store_strobe, p0f}, {2'h3, ep});
    pulse_wdt();
    repeat (8) @(posedge mclk);
    chk(run, 1'b0);
    int_n <= 2'h2;
    wt(1'b0, 1'b1);
    int_n <= 2'h3;
    chk({crst, xtal}, 2'h0);
    rchk(pcm_pkg::OFF_STAT, 32'h12);
    wreg(pcm_pkg::OFF_PCTL, 8'h02);
    wt(1'b0, 1'b0);
    rpin <= 1'b1;
    wt(1'b1, 1'b1);
    // Held well past two machine cycles of the slow rate
    repeat (140) @(posedge mclk);
    rpin <= 1'b0;
    wt(1'b1, 1'b0);
    chk({run, xtal}, 2'h3);
    per(4);
    rreg(pcm_pkg::OFF_STAT);
    chk(q[0], 1'b0);
    $display("power test done");
    wreg(pcm_pkg::OFF_WDG, 8'h01);
    pulse_wdt();
    wt(1'b1, 1'b1);
    chk(n >= 512 && n <= 525, 1'b1);
    wt(1'b1, 1'b0);
    rreg(pcm_pkg::OFF_STAT);
    chk(q[2], 1'b1);
    $display("watchdog test done");
    report_and_stop();
  end
endmodule

// >>> pcm_reset_ctl.sv
// Reset pin sampling, reset stretching and watchdog reset timing
module pcm_reset_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Machine-cycle timing
  pcm_tick_if.usr tif,
  // Reset sources
  input wire logic pin_hi,
  input wire logic wdt_to,
  input wire logic wdt_clr,
  input wire logic wdt_ren,
  // Results
  output logic core_rst,
  output logic wd_fire
);
  typedef struct packed {
    pcm_pkg::pcm_rst_st_t st;
    logic [9:0] cnt;
    logic rst_o;
    logic fire;
  } pcm_rs_t;

  pcm_rs_t s_q;
  pcm_rs_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    unique case (s_q.st)
      pcm_pkg::RS_IDLE: begin
        if (tif.tick && pin_hi) begin
          s_d.st = pcm_pkg::RS_HOLD;
        end else if (wdt_to && wdt_ren) begin
          s_d.st = pcm_pkg::RS_WDWAIT;
          s_d.cnt = '0;
        end
      end
      pcm_pkg::RS_WDWAIT: begin
        if (tif.tick && pin_hi) begin
          s_d.st = pcm_pkg::RS_HOLD;
        end else if (wdt_clr) begin
          s_d.st = pcm_pkg::RS_IDLE;
        end else if (s_q.cnt == pcm_pkg::WDT_LAST) begin
          if (tif.tick) begin
            s_d.st = pcm_pkg::RS_STRETCH;
            s_d.cnt = '0;
            s_d.fire = 1'b1;
          end
        end else if (tif.run) begin
          s_d.cnt = s_q.cnt + 10'h001;
        end
      end
      pcm_pkg::RS_HOLD: begin
        if (tif.tick && !pin_hi) begin
          s_d.st = pcm_pkg::RS_STRETCH;
          s_d.cnt = '0;
        end
      end
      pcm_pkg::RS_STRETCH: begin
        if (tif.tick) begin
          if (pin_hi) begin
            s_d.st = pcm_pkg::RS_HOLD;
          end else if (s_q.cnt == pcm_pkg::RST_STRETCH_LAST) begin
            s_d.st = pcm_pkg::RS_IDLE;
          end else begin
            s_d.cnt = s_q.cnt + 10'h001;
          end
        end
      end
    endcase
    s_d.rst_o = (s_d.st == pcm_pkg::RS_HOLD) || (s_d.st == pcm_pkg::RS_STRETCH);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.st <= pcm_pkg::RS_IDLE;
      s_q.cnt <= '0;
      s_q.rst_o <= 1'b0;
      s_q.fire <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_rst = s_q.rst_o;
  assign wd_fire = s_q.fire;
endmodule

// >>> pcm_tick_if.sv
// Machine-cycle timing signals shared between the block's parts
interface pcm_tick_if;
  logic run;
  pcm_pkg::pcm_div_t div_req;
  logic tick;
  modport gen (input run, input div_req, output tick);
  modport usr (input run, input tick);
endinterface
